/* File: timer_buffer_pkg.sv */
// constants for the timer buffer and counter control block
package timer_buffer_pkg;
    // ==========================================================
    // register map, byte offsets on the internal 16-bit bus
    localparam logic [3:0] OFF_CTRL0     = 4'h0;   // counter_control ch0..ch4 at 0,2,4,6,8 (low byte)
    localparam logic [3:0] OFF_FUNC      = 4'ha;   // timer_function_control
    localparam logic [3:0] OFF_BUF_A3    = 4'hc;
    localparam logic [3:0] OFF_BUF_B3    = 4'he;
    localparam logic [4:0] OFF_BUF_A4    = 5'h10;
    localparam logic [4:0] OFF_BUF_B4    = 5'h12;
    localparam int         ADDR_W        = 5;
    // ==========================================================
    // field positions and reset values
    localparam int         CC_FIXED_BIT  = 7;
    localparam int         CC_CLR_LSB    = 5;
    localparam int         CC_EDGE_HI    = 4;
    localparam int         CC_EDGE_LO    = 3;
    localparam int         CC_PRE_HI     = 2;
    localparam logic [7:0] CC_RESET      = 8'h80;
    localparam logic [15:0] BUF_RESET    = 16'hffff;
    localparam logic [15:0] CNT_CLEARED  = 16'h0000;
    // ==========================================================
    // clear select codes
    localparam logic [1:0] CLR_NONE      = 2'h0;
    localparam logic [1:0] CLR_BY_A      = 2'h1;
    localparam logic [1:0] CLR_BY_B      = 2'h2;
    localparam logic [1:0] CLR_SYNC      = 2'h3;
    localparam int         NUM_CH        = 5;
    localparam int         PHASE_CH      = 2;
    localparam int         SYNC_STAGES   = 3;
endpackage : timer_buffer_pkg

/* File: timer_count_source.sv */
// per-channel count source selection and edge qualification
`timescale 1ns/100ps
module timer_count_source
    import timer_buffer_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] control_i,
    input  wire logic [3:0] div_fall_i,   // falling edges of phi, phi/2, phi/4, phi/8
    input  wire logic [3:0] ext_rise_i,
    input  wire logic [3:0] ext_fall_i,
    input  wire logic       phase_mode_i,
    input  wire logic       phase_step_i,
    output logic            count_o
);
    typedef struct packed {
        logic cnt;
    } st_t;
    st_t st_q, st_d;
    logic [1:0] sel;
    // ==========================================================
    // source choice
    always_comb begin
        st_d = st_q;
        sel  = control_i[1:0];
        if (phase_mode_i) begin
            st_d.cnt = phase_step_i;
        end else if (!control_i[CC_PRE_HI]) begin
            st_d.cnt = div_fall_i[sel];
        end else if (control_i[CC_EDGE_HI]) begin
            st_d.cnt = ext_rise_i[sel] | ext_fall_i[sel];
        end else if (control_i[CC_EDGE_LO]) begin
            st_d.cnt = ext_fall_i[sel];
        end else begin
            st_d.cnt = ext_rise_i[sel];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign count_o = st_q.cnt;
endmodule : timer_count_source

/* File: timer_buffer_ctrl.sv */
// counter control registers and channel 3/4 buffer registers of the timer unit
`timescale 1ns/100ps
module timer_buffer_ctrl
    import timer_buffer_pkg::*;
(
    input  wire logic                  CLOCK_I,
    input  wire logic                  RST_I,
    input  wire logic                  STANDBY_I,
    input  wire logic [ADDR_W-1:0]     ADDR_I,
    input  wire logic                  WR_I,
    input  wire logic [1:0]            BYTE_EN_I,    // [1] high byte, [0] low byte
    input  wire logic [15:0]           WDATA_I,
    output logic      [15:0]           RDATA_O,
    input  wire logic                  EXT_CLOCK_IN_A_I,
    input  wire logic                  EXT_CLOCK_IN_B_I,
    input  wire logic                  EXT_CLOCK_IN_C_I,
    input  wire logic                  EXT_CLOCK_IN_D_I,
    input  wire logic                  PHASE_COUNT_FLAG_I,
    input  wire logic                  PHASE_STEP_I,
    input  wire logic [NUM_CH-1:0]     MATCH_A_I,    // compare match or capture events
    input  wire logic [NUM_CH-1:0]     MATCH_B_I,
    input  wire logic [NUM_CH-1:0]     CAPTURE_MODE_A_I,
    input  wire logic [NUM_CH-1:0]     CAPTURE_MODE_B_I,
    input  wire logic [NUM_CH-1:0]     SYNC_CLEAR_I,
    input  wire logic [15:0]           GENERAL_REG_A3_I,
    input  wire logic [15:0]           GENERAL_REG_B3_I,
    input  wire logic [15:0]           GENERAL_REG_A4_I,
    input  wire logic [15:0]           GENERAL_REG_B4_I,
    output logic      [NUM_CH-1:0]     COUNT_EN_O,
    output logic      [NUM_CH-1:0]     COUNTER_CLEAR_O,
    output logic      [3:0]            LOAD_GENERAL_O,  // a3,b3,a4,b4
    output logic      [15:0]           LOAD_DATA_A3_O,
    output logic      [15:0]           LOAD_DATA_B3_O,
    output logic      [15:0]           LOAD_DATA_A4_O,
    output logic      [15:0]           LOAD_DATA_B4_O
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [NUM_CH-1:0][7:0]     ctrl;
        logic [3:0]                 buf_en;
        logic [3:0][15:0]           bufr;
        logic [2:0]                 div;
        logic [3:0][SYNC_STAGES-1:0] ext_sync;
        logic [NUM_CH-1:0]          clr;
        logic [15:0]                rdata;
    } st_t;
    st_t st_q, st_d;

    logic [3:0]        ext_pin;
    logic [3:0]        ext_rise;
    logic [3:0]        ext_fall;
    logic [3:0]        div_fall;
    logic [3:0]        pair_event;
    logic [3:0]        pair_capture;
    logic [3:0][15:0]  pair_general;
    logic              init;

    assign ext_pin      = {EXT_CLOCK_IN_D_I, EXT_CLOCK_IN_C_I, EXT_CLOCK_IN_B_I, EXT_CLOCK_IN_A_I};
    assign init         = RST_I | STANDBY_I;
    // pair order a3,b3,a4,b4 matches buffer index
    assign pair_event   = {MATCH_B_I[4], MATCH_A_I[4], MATCH_B_I[3], MATCH_A_I[3]};
    assign pair_capture = {CAPTURE_MODE_B_I[4], CAPTURE_MODE_A_I[4], CAPTURE_MODE_B_I[3], CAPTURE_MODE_A_I[3]};
    assign pair_general = {GENERAL_REG_B4_I, GENERAL_REG_A4_I, GENERAL_REG_B3_I, GENERAL_REG_A3_I};

    // ==========================================================
    // edge detect on pins: only stages 2 and 3 are compared
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ext
            assign ext_rise[g] = st_q.ext_sync[g][1] & ~st_q.ext_sync[g][2];
            assign ext_fall[g] = ~st_q.ext_sync[g][1] & st_q.ext_sync[g][2];
        end
    endgenerate

    // falling edge of phi every cycle, of phi/2^n when divider bits wrap
    assign div_fall = {&st_q.div[2:0], &st_q.div[1:0], st_q.div[0], 1'b1};

    generate
        for (g = 0; g < NUM_CH; g++) begin : g_src
            timer_count_source u_src (
                .clk_i        (CLOCK_I),
                .rst_i        (init),
                .control_i    (st_q.ctrl[g]),
                .div_fall_i   (div_fall),
                .ext_rise_i   (ext_rise),
                .ext_fall_i   (ext_fall),
                .phase_mode_i ((g == PHASE_CH) && PHASE_COUNT_FLAG_I),
                .phase_step_i (PHASE_STEP_I),
                .count_o      (COUNT_EN_O[g])
            );
        end
    endgenerate

    // ==========================================================
    // next state
    always_comb begin
        st_d = st_q;
        st_d.div = st_q.div + 3'h1;
        for (int i = 0; i < 4; i++) begin
            st_d.ext_sync[i] = {st_q.ext_sync[i][1:0], ext_pin[i]};
        end
        // counter clearing
        for (int c = 0; c < NUM_CH; c++) begin
            case (st_q.ctrl[c][6:CC_CLR_LSB])
                CLR_BY_A: st_d.clr[c] = MATCH_A_I[c];
                CLR_BY_B: st_d.clr[c] = MATCH_B_I[c];
                CLR_SYNC: st_d.clr[c] = SYNC_CLEAR_I[c];
                default:  st_d.clr[c] = 1'b0;
            endcase
        end
        // bus writes, byte lanes
        if (WR_I) begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (ADDR_I == ADDR_W'(2 * c) && BYTE_EN_I[0]) begin
                    st_d.ctrl[c] = {1'b1, WDATA_I[6:0]};
                end
            end
            if (ADDR_I == ADDR_W'(OFF_FUNC) && BYTE_EN_I[0]) begin
                st_d.buf_en = WDATA_I[3:0];
            end
            for (int b = 0; b < 4; b++) begin
                if (ADDR_I == ADDR_W'(OFF_BUF_A3) + ADDR_W'(2 * b)) begin
                    if (BYTE_EN_I[0]) st_d.bufr[b][7:0]  = WDATA_I[7:0];
                    if (BYTE_EN_I[1]) st_d.bufr[b][15:8] = WDATA_I[15:8];
                end
            end
        end
        // capture into buffer wins over a software write in the same cycle
        for (int b = 0; b < 4; b++) begin
            if (st_q.buf_en[b] && pair_capture[b] && pair_event[b]) begin
                st_d.bufr[b] = pair_general[b];
            end
        end
        // read mux, registered
        st_d.rdata = 16'h0000;
        for (int c = 0; c < NUM_CH; c++) begin
            if (ADDR_I == ADDR_W'(2 * c)) st_d.rdata = {8'h00, st_q.ctrl[c]};
        end
        if (ADDR_I == ADDR_W'(OFF_FUNC)) st_d.rdata = {12'h000, st_q.buf_en};
        for (int b = 0; b < 4; b++) begin
            if (ADDR_I == ADDR_W'(OFF_BUF_A3) + ADDR_W'(2 * b)) st_d.rdata = st_q.bufr[b];
        end
    end

    // ==========================================================
    // registers; standby acts like reset
    always_ff @(posedge CLOCK_I) begin
        if (init) begin
            st_q.ctrl     <= {NUM_CH{CC_RESET}};
            st_q.buf_en   <= 4'h0;
            st_q.bufr     <= {4{BUF_RESET}};
            st_q.div      <= 3'h0;
            st_q.ext_sync <= '0;
            st_q.clr      <= '0;
            st_q.rdata    <= 16'h0000;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // outputs; compare load is combinational so it lands in the match cycle
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            LOAD_GENERAL_O[b] = st_q.buf_en[b] & ~pair_capture[b] & pair_event[b];
        end
    end
    assign LOAD_DATA_A3_O  = st_q.bufr[0];
    assign LOAD_DATA_B3_O  = st_q.bufr[1];
    assign LOAD_DATA_A4_O  = st_q.bufr[2];
    assign LOAD_DATA_B4_O  = st_q.bufr[3];
    assign COUNTER_CLEAR_O = st_q.clr;
    assign RDATA_O         = st_q.rdata;

    // ==========================================================
    // checks
    AST_FIXED_BIT: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        st_q.ctrl[0][CC_FIXED_BIT] && st_q.ctrl[4][CC_FIXED_BIT])
        else $error("control bit 7 not one");
    AST_LOAD_SAME: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (st_q.buf_en[0] && !CAPTURE_MODE_A_I[3] && MATCH_A_I[3]) |-> LOAD_GENERAL_O[0])
        else $error("compare load missing");
    AST_NO_LOAD_OFF: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        !st_q.buf_en[1] |-> !LOAD_GENERAL_O[1])
        else $error("load while buffering off");
    AST_CAPTURE: assert property (@(posedge CLOCK_I) disable iff (init)
        (st_q.buf_en[2] && CAPTURE_MODE_A_I[4] && MATCH_A_I[4]) |=> (st_q.bufr[2] == $past(GENERAL_REG_A4_I)))
        else $error("capture into buffer missing");
    AST_BUF_RESET: assert property (@(posedge CLOCK_I)
        $past(init) |-> (st_q.bufr[3] == BUF_RESET && st_q.ctrl[1] == CC_RESET))
        else $error("reset value wrong");
    AST_CLR_A: assert property (@(posedge CLOCK_I) disable iff (init)
        (st_q.ctrl[0][6:5] == CLR_BY_A && MATCH_A_I[0]) |=> COUNTER_CLEAR_O[0])
        else $error("clear by A missing");
    AST_CLR_NONE: assert property (@(posedge CLOCK_I) disable iff (init)
        (st_q.ctrl[1][6:5] == CLR_NONE) |=> !COUNTER_CLEAR_O[1] || $past(WR_I))
        else $error("clear with no source");
    AST_INT_CLK: assert property (@(posedge CLOCK_I) disable iff (init)
        (!$past(init) && st_q.ctrl[0][2:0] == 3'h0 && $past(st_q.ctrl[0][2:0]) == 3'h0) |-> COUNT_EN_O[0])
        else $error("phi count missing");

    // ==========================================================
    // further checks
    // the count source stages are cleared while init is high, so any
    // check that looks back one cycle at a count or read value skips the
    // first edge after reset or standby; otherwise it would see the
    // cleared pipeline and fire although the block behaves.
    // the clear output lags its event by one edge, the compare load does
    // not, which is why the two kinds of check use different implications.
    // capture and compare share one event pin per register, the mode pin
    // tells them apart; a check on one must not be fooled by the other.
    // byte lane checks only cover the lanes that software actually uses,
    // the other lanes follow from the same loop and are not repeated here.
    // limitation: the synchronous clear is only forwarded, its grouping
    // of channels lives outside this block and is not checked here.

    // clear by B follows a B event one edge later
    AST_CLR_B: assert property (@(posedge CLOCK_I) disable iff (init)
        (st_q.ctrl[1][6:5] == CLR_BY_B && MATCH_B_I[1]) |=> COUNTER_CLEAR_O[1])
        else $error("clear by B missing");

    // synchronous clear code forwards the group clear
    AST_CLR_SYNC: assert property (@(posedge CLOCK_I) disable iff (init)
        (st_q.ctrl[1][6:5] == CLR_SYNC && SYNC_CLEAR_I[1]) |=> COUNTER_CLEAR_O[1])
        else $error("synchronous clear missing");

    // a clear pulse always has a cause in the previous cycle
    AST_CLR_CAUSE: assert property (@(posedge CLOCK_I) disable iff (init)
        COUNTER_CLEAR_O[0] |-> $past(MATCH_A_I[0] || MATCH_B_I[0] || SYNC_CLEAR_I[0]))
        else $error("clear without event");

    // capture mode never reloads the general register
    AST_CAP_NO_LOAD: assert property (@(posedge CLOCK_I) disable iff (init)
        CAPTURE_MODE_B_I[3] |-> !LOAD_GENERAL_O[1])
        else $error("load in capture mode");

    // capture into buffer b of channel 3
    AST_CAPTURE_B3: assert property (@(posedge CLOCK_I) disable iff (init)
        (st_q.buf_en[1] && CAPTURE_MODE_B_I[3] && MATCH_B_I[3]) |=> (st_q.bufr[1] == $past(GENERAL_REG_B3_I)))
        else $error("capture into buffer b3 missing");

    // no load at all while every pair has buffering off
    AST_NO_LOAD_ALL: assert property (@(posedge CLOCK_I) disable iff (init)
        (st_q.buf_en == 4'h0) |-> (LOAD_GENERAL_O == 4'h0))
        else $error("load with buffering off");

    // a load only happens on its own event
    AST_LOAD_CAUSE: assert property (@(posedge CLOCK_I) disable iff (init)
        LOAD_GENERAL_O[3] |-> MATCH_B_I[4])
        else $error("load without match");

    // standby restores buffers and control registers
    AST_STANDBY: assert property (@(posedge CLOCK_I)
        $past(STANDBY_I) |-> (st_q.bufr[0] == BUF_RESET && st_q.ctrl[4] == CC_RESET))
        else $error("standby value wrong");

    // low lane write leaves the high byte of a buffer alone
    AST_LANE_LO: assert property (@(posedge CLOCK_I) disable iff (init)
        (WR_I && ADDR_I == ADDR_W'(OFF_BUF_A3) && BYTE_EN_I == 2'h1
         && !(st_q.buf_en[0] && pair_capture[0] && pair_event[0]))
        |=> (st_q.bufr[0][15:8] == $past(st_q.bufr[0][15:8])))
        else $error("high byte changed by low lane write");

    // control write lands in bits 6..0
    AST_CTRL_WRITE: assert property (@(posedge CLOCK_I) disable iff (init)
        (WR_I && ADDR_I == ADDR_W'(OFF_CTRL0) && BYTE_EN_I[0]) |=> (st_q.ctrl[0][6:0] == $past(WDATA_I[6:0])))
        else $error("control write lost");

    // control registers have no high byte, such a write changes nothing
    AST_CTRL_HI_LANE: assert property (@(posedge CLOCK_I) disable iff (init)
        (WR_I && ADDR_I == ADDR_W'(OFF_CTRL0) + 5'h02 && BYTE_EN_I == 2'h2)
        |=> (st_q.ctrl[1] == $past(st_q.ctrl[1])))
        else $error("control changed by high lane");

    // read of a control register shows bit 7 set
    AST_RD_FIXED: assert property (@(posedge CLOCK_I) disable iff (init)
        (!$past(init) && $past(ADDR_I) == ADDR_W'(OFF_CTRL0)) |-> RDATA_O[CC_FIXED_BIT])
        else $error("control read bit 7 clear");

    // phase counting on channel 2 follows the step input
    AST_PHASE: assert property (@(posedge CLOCK_I) disable iff (init)
        (!$past(init) && $past(PHASE_COUNT_FLAG_I)) |-> (COUNT_EN_O[2] == $past(PHASE_STEP_I)))
        else $error("phase count wrong");

    // phi/2 never gives two count pulses in a row
    AST_DIV2: assert property (@(posedge CLOCK_I) disable iff (init)
        (st_q.ctrl[0][2:0] == 3'h1 && $past(st_q.ctrl[0][2:0]) == 3'h1 && COUNT_EN_O[0]) |=> !COUNT_EN_O[0])
        else $error("phi/2 pulses too close");
endmodule : timer_buffer_ctrl

/* File: timer_channel_model.sv */
// general register stand-in for channels 3 and 4, reloaded from the buffers
`timescale 1ns/100ps
module timer_channel_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  load_i,
    input  wire logic [15:0] data_a3_i,
    input  wire logic [15:0] data_b3_i,
    input  wire logic [15:0] data_a4_i,
    input  wire logic [15:0] data_b4_i,
    output logic      [15:0] gr_a3_o,
    output logic      [15:0] gr_b3_o,
    output logic      [15:0] gr_a4_o,
    output logic      [15:0] gr_b4_o
);
    // ==========================================================
    // distinct start values so a capture shows which register moved
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gr_a3_o <= 16'h0a03;
            gr_b3_o <= 16'h0b03;
            gr_a4_o <= 16'h0a04;
            gr_b4_o <= 16'h0b04;
        end else begin
            if (load_i[0]) gr_a3_o <= data_a3_i;
            if (load_i[1]) gr_b3_o <= data_b3_i;
            if (load_i[2]) gr_a4_o <= data_a4_i;
            if (load_i[3]) gr_b4_o <= data_b4_i;
        end
    end
endmodule : timer_channel_model

/* File: testbench.sv */
// register-level tests of the timer buffer and counter control block
`timescale 1ns/100ps
module testbench;
    import timer_buffer_pkg::*;
    // ==========================================================
    // stimulus and observed signals
    logic        clk = 1'b0, rst = 1'b1, standby = 1'b0, wr = 1'b0, phase_flag = 1'b0, phase_step = 1'b0;
    logic [4:0]  addr = 5'h00, match_a = 5'h00, match_b = 5'h00, cap_a = 5'h00, cap_b = 5'h00, sync_clr = 5'h00;
    logic [1:0]  be = 2'h3;
    logic [3:0]  ext = 4'h0, load;
    logic [15:0] wdata = 16'h0000, rdata, gr_a3, gr_b3, gr_a4, gr_b4, ld_a3, ld_b3, ld_a4, ld_b4;
    logic [4:0]  count_en, clr;
    int          mismatches = 0, comparisons = 0, n;
    always #2.5 clk = ~clk;
    timer_buffer_ctrl u_dut (.CLOCK_I(clk), .RST_I(rst), .STANDBY_I(standby), .ADDR_I(addr), .WR_I(wr),
        .BYTE_EN_I(be), .WDATA_I(wdata), .RDATA_O(rdata), .EXT_CLOCK_IN_A_I(ext[0]), .EXT_CLOCK_IN_B_I(ext[1]),
        .EXT_CLOCK_IN_C_I(ext[2]), .EXT_CLOCK_IN_D_I(ext[3]), .PHASE_COUNT_FLAG_I(phase_flag),
        .PHASE_STEP_I(phase_step), .MATCH_A_I(match_a), .MATCH_B_I(match_b), .CAPTURE_MODE_A_I(cap_a),
        .CAPTURE_MODE_B_I(cap_b), .SYNC_CLEAR_I(sync_clr), .GENERAL_REG_A3_I(gr_a3), .GENERAL_REG_B3_I(gr_b3),
        .GENERAL_REG_A4_I(gr_a4), .GENERAL_REG_B4_I(gr_b4), .COUNT_EN_O(count_en), .COUNTER_CLEAR_O(clr),
        .LOAD_GENERAL_O(load), .LOAD_DATA_A3_O(ld_a3), .LOAD_DATA_B3_O(ld_b3), .LOAD_DATA_A4_O(ld_a4),
        .LOAD_DATA_B4_O(ld_b4));
    timer_channel_model u_part (.clk_i(clk), .rst_i(rst), .load_i(load), .data_a3_i(ld_a3), .data_b3_i(ld_b3),
        .data_a4_i(ld_a4), .data_b4_i(ld_b4), .gr_a3_o(gr_a3), .gr_b3_o(gr_b3), .gr_a4_o(gr_a4), .gr_b4_o(gr_b4));
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [4:0] a, input logic [1:0] b, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        be <= b;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // read data is registered, so it is looked at one edge after the address
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        #1 chk(rdata, exp);
    endtask : rd_chk
    // one-cycle event; load is combinational, the clear follows one edge later
    task automatic fire(input logic [4:0] ma, mb, sy, input logic [3:0] exp_ld, input logic [4:0] exp_clr);
        @(posedge clk);
        match_a <= ma;
        match_b <= mb;
        sync_clr <= sy;
        #1 chk({12'h000, load}, {12'h000, exp_ld});
        @(posedge clk);
        match_a <= 5'h00;
        match_b <= 5'h00;
        sync_clr <= 5'h00;
        #1 chk({11'h000, clr}, {11'h000, exp_clr});
    endtask : fire
    // counts pulses of one channel while pin A or the phase step is wiggled
    task automatic run(input int ch, input int mode, input int len, input int exp);
        n = 0;
        for (int i = 0; i < len; i++) begin
            @(posedge clk);
            ext[0] <= (mode == 1 && i < 16) ? i[2] : 1'b0;
            phase_step <= (mode == 2 && i < 6) ? i[0] : 1'b0;
            #1 if (count_en[ch] === 1'b1) n++;
        end
        chk(16'(n), 16'(exp));
    endtask : run
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int c = 0; c < NUM_CH; c++) rd_chk(5'(2 * c), 16'h0080);
        for (int k = 0; k < 4; k++) rd_chk(5'(5'h0c + 2 * k), 16'hffff);
        rd_chk(5'h0a, 16'h0000);
        rd_chk(5'h14, 16'h0000);
        wr_reg(5'h02, 2'h3, 16'h00ff);
        rd_chk(5'h02, 16'h00ff);
        wr_reg(5'h02, 2'h3, 16'h0000);
        rd_chk(5'h02, 16'h0080);
        wr_reg(5'h02, 2'h2, 16'hffff);
        rd_chk(5'h02, 16'h0080);
        wr_reg(5'h0c, 2'h3, 16'h1234);
        wr_reg(5'h0c, 2'h1, 16'h77ab);
        rd_chk(5'h0c, 16'h12ab);
        wr_reg(5'h0c, 2'h2, 16'hcd77);
        rd_chk(5'h0c, 16'hcdab);
        fire(5'h08, 5'h00, 5'h00, 4'h0, 5'h00);
        wr_reg(5'h0a, 2'h3, 16'h000d);
        fire(5'h18, 5'h18, 5'h00, 4'hd, 5'h00);
        chk(gr_a3, 16'hcdab);
        chk(gr_b3, 16'h0b03);
        cap_b <= 5'h08;
        wr_reg(5'h0a, 2'h3, 16'h0002);
        fire(5'h00, 5'h08, 5'h00, 4'h0, 5'h00);
        rd_chk(5'h0e, 16'h0b03);
        for (int code = 0; code < 4; code++) begin
            wr_reg(5'h02, 2'h3, 16'(code << CC_CLR_LSB));
            fire(5'h02, 5'h00, 5'h00, 4'h0, (code == 1) ? 5'h02 : 5'h00);
            fire(5'h00, 5'h02, 5'h00, 4'h0, (code == 2) ? 5'h02 : 5'h00);
            fire(5'h00, 5'h00, 5'h02, 4'h0, (code == 3) ? 5'h02 : 5'h00);
        end
        cap_a <= 5'h02;
        wr_reg(5'h02, 2'h3, 16'h0020);
        fire(5'h02, 5'h00, 5'h00, 4'h0, 5'h02);
        for (int p = 0; p < 4; p++) begin
            wr_reg(5'h00, 2'h3, 16'(p));
            repeat (20) @(posedge clk);
            run(0, 0, 16, 16 >> p);
        end
        for (int k = 0; k < 4; k++) begin
            wr_reg(5'h00, 2'h3, 16'(8'h04 + 8 * k));
            repeat (8) @(posedge clk);
            run(0, 1, 40, (k < 2) ? 2 : 4);
        end
        wr_reg(5'h00, 2'h3, 16'h0005);
        run(0, 1, 40, 0);
        phase_flag <= 1'b1;
        wr_reg(5'h04, 2'h3, 16'h0000);
        repeat (8) @(posedge clk);
        run(2, 2, 40, 3);
        @(posedge clk);
        standby <= 1'b1;
        @(posedge clk);
        standby <= 1'b0;
        rd_chk(5'h0c, 16'hffff);
        rd_chk(5'h02, 16'h0080);
        tally_and_finish();
    end
endmodule : testbench
